// ==== bench/lfo_ctrl_tb.sv ====
// self-checking bench for the oscillator control register block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; $display("unexpected %s expected %h seen %h", n, e, g); end end
module lfo_ctrl_tb;
   localparam int P = lfo_pkg::ULP_DIV_CYC;
   localparam logic [7:0] ADR [4] = '{lfo_pkg::OFS_XOSC, lfo_pkg::OFS_SLOW,
                                      lfo_pkg::OFS_ULP, lfo_pkg::OFS_FAST};
   localparam logic [31:0] MSK [4] = '{lfo_pkg::XOSC_WMASK, lfo_pkg::SLOW_WMASK,
                                       lfo_pkg::ULP_WMASK, lfo_pkg::FAST_WMASK};
   // lock bits kept clear until the lock test
   localparam logic [31:0] CLR [4] = '{32'h00000000, 32'h00001000, 32'h00000080, 32'h00000000};
   // bench-driven inputs
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic standby_sleep = 1'b0;
   logic slow_req = 1'b0;
   logic fast_req = 1'b0;
   logic [4:0] ulp_ld;
   logic [1:0] rng_ld;
   logic [11:0] ftrim_ld;
   // design outputs
   logic [31:0] prdata;
   logic pready, pslverr, xtal, gpio_free, ext_en, slow_run, ready, k32, k1;
   logic fast_run, div_tick;
   logic [6:0] slow_trim;
   logic [4:0] ulp_trim;
   logic [1:0] rng;
   logic [11:0] fast_trim;
   // bench state and reference model
   int mismatches = 0;
   int checks = 0;
   int n, m, k, lim;
   int startup_tbl [8] = '{3, 4, 6, 10, 18, 34, 66, 130};
   logic [31:0] seed = 32'h00000053;
   logic [31:0] rdv, d, e;
   logic errv;

   lfo_ctrl #(.ADDR_W(8)) lfo_ctrl_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .standby_sleep(standby_sleep), .slow_clk_request(slow_req), .fast_clk_request(fast_req),
      .ulp_trim_load(ulp_ld), .fast_range_load(rng_ld), .fast_trim_load(ftrim_ld),
      .crystal_pad_select(xtal), .output_pad_gpio_free(gpio_free),
      .ext_slow_osc_enable(ext_en), .slow_osc_run(slow_run), .slow_trim(slow_trim),
      .internal_slow_ready_flag(ready), .khz32_tick(k32), .khz1_tick(k1),
      .ulp_trim(ulp_trim), .fast_osc_run(fast_run), .frequency_range_select(rng),
      .fast_trim(fast_trim), .fast_div_tick(div_tick));

   // 25 MHz clock
   always #20 pclk = ~pclk;

   // xorshift source, seeded at 83
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // one apb transfer, waits for pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int t;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 16);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (t >= 16) mismatches++;
   endtask

   task automatic finish_test();
      if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // watchdog over the longest spans
   initial begin
      repeat (90000) @(posedge pclk);
      mismatches++;
      finish_test();
   end

   initial begin
      ulp_ld <= 5'(rnd());
      rng_ld <= 2'(rnd());
      ftrim_ld <= 12'(rnd());
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      `CHK("ulp_trim", ulp_ld, ulp_trim)
      `CHK("fast_trim", ftrim_ld, fast_trim)
      `CHK("range", rng_ld, rng)
      apb(1'b0, lfo_pkg::OFS_SLOW, 32'h0);
      `CHK("slow_reset", 32'h003F0080, rdv)
      apb(1'b0, lfo_pkg::OFS_FAST, 32'h0);
      e = (32'h87070382 & 32'h3000FFFF) | {rng_ld, 2'b00, ftrim_ld, 16'h0000};
      `CHK("fast_reset", e, rdv)
      apb(1'b0, lfo_pkg::OFS_ULP, 32'h0);
      `CHK("ulp_reset", {27'h0, ulp_ld}, rdv)
      // random writes, reserved bits read zero
      for (n = 0; n < 12; n++) begin
         k = n % 4;
         d = rnd() & ~CLR[k];
         apb(1'b1, ADR[k], d);
         apb(1'b0, ADR[k], 32'h0);
         `CHK("readback", d & MSK[k], rdv)
         if (k == 0) `CHK("pad_sel", {d[2], ~d[2], d[1]}, {xtal, gpio_free, ext_en})
         if (k == 1) `CHK("slow_trim", d[22:16], slow_trim)
      end
      // unmapped offset: error, reads zero
      apb(1'b1, 8'h40, 32'hFFFFFFFF);
      `CHK("unmapped_err", 1'b1, errv)
      apb(1'b0, 8'h40, 32'h0);
      `CHK("unmapped_rd", 32'h0, rdv)
      for (k = 0; k < 32; k++) begin
         d = {24'h0, k[1], k[2], 4'h0, k[0], 1'b0};
         standby_sleep <= k[3];
         slow_req <= k[4];
         fast_req <= k[4];
         apb(1'b1, lfo_pkg::OFS_SLOW, d);
         apb(1'b1, lfo_pkg::OFS_FAST, d);
         apb(1'b0, lfo_pkg::OFS_FAST, 32'h0);
         `CHK("fast_en_rb", k[0], rdv[1])
         repeat (3) @(posedge pclk);
         e[0] = k[0] & (~k[3] | k[2]) & (~k[1] | k[4]);
         `CHK("slow_run", e[0], slow_run)
         `CHK("fast_run", e[0], fast_run)
         apb(1'b0, lfo_pkg::OFS_STATUS, 32'h0);
         `CHK("status_run", {e[0], e[0]}, rdv[2:1])
      end
      standby_sleep <= 1'b0;
      for (k = 0; k < 4; k++) begin
         apb(1'b1, lfo_pkg::OFS_FAST, 32'h00000002 | (k << 8));
         repeat (2) @(posedge pclk);
         n = 0;
         while (div_tick !== 1'b1 && n < 64) begin
            @(posedge pclk);
            n++;
         end
         n = 0;
         do begin
            @(posedge pclk);
            n++;
         end while (div_tick !== 1'b1 && n < 64);
         `CHK("div_gap", 1 << k, n)
      end
      // start-up span counted in low-power periods
      for (k = 0; k < 3; k++) begin
         apb(1'b1, lfo_pkg::OFS_SLOW, 32'h0);
         repeat (4) @(posedge pclk);
         `CHK("ready_drop", 1'b0, ready)
         apb(1'b1, lfo_pkg::OFS_SLOW, 32'h00000002 | (k << 8));
         lim = startup_tbl[k] + 2;
         n = 0;
         while (ready !== 1'b1 && n < 200 * P) begin
            @(posedge pclk);
            n++;
         end
         `CHK("startup", 1'b1, n >= (lim - 1) * P && n <= lim * P + 4)
      end
      // 32 slow ticks per 1 kHz tick
      apb(1'b1, lfo_pkg::OFS_SLOW, 32'h0000020E);
      m = 0;
      while (k1 !== 1'b1 && m < 40 * P) begin
         @(posedge pclk);
         m++;
      end
      n = 0;
      m = 0;
      do begin
         @(posedge pclk);
         m++;
         if (k32 === 1'b1) n++;
      end while (k1 !== 1'b1 && m < 40 * P);
      `CHK("k32_per_k1", 32, n)
      // gates shut, no ticks
      apb(1'b1, lfo_pkg::OFS_SLOW, 32'h00000202);
      n = 0;
      repeat (2 * P) begin
         @(posedge pclk);
         if (k32 !== 1'b0 || k1 !== 1'b0) n++;
      end
      `CHK("gated_ticks", 0, n)
      apb(1'b1, lfo_pkg::OFS_SLOW, 32'h00051000);
      apb(1'b1, lfo_pkg::OFS_SLOW, 32'h00000002);
      apb(1'b0, lfo_pkg::OFS_SLOW, 32'h0);
      `CHK("slow_lock", 32'h00051000, rdv)
      apb(1'b1, lfo_pkg::OFS_ULP, 32'h00000085);
      apb(1'b1, lfo_pkg::OFS_ULP, 32'h0000001F);
      apb(1'b0, lfo_pkg::OFS_ULP, 32'h0);
      `CHK("ulp_lock", 32'h00000085, rdv)
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      apb(1'b1, lfo_pkg::OFS_SLOW, 32'h00000004);
      apb(1'b0, lfo_pkg::OFS_SLOW, 32'h0);
      `CHK("unlock_slow", 32'h00000004, rdv)
      apb(1'b1, lfo_pkg::OFS_ULP, 32'h00000011);
      apb(1'b0, lfo_pkg::OFS_ULP, 32'h0);
      `CHK("unlock_ulp", 32'h00000011, rdv)
      finish_test();
   end
endmodule
`undef CHK
`default_nettype wire

// ==== inc/lfo_pkg.sv ====
// package with register map, reset values and helpers for the oscillator controls
// Functional notes
// - pad select: external clock or crystal
// - slow oscillator runs only when enabled
// - reserved bits write zero, read zero
// - slow control lock blocks further writes
// - start-up code selects 3 to 130 cycles
// - start-up counter clocked by low-power source
// - ready after start-up plus two cycles
// - on-request mode runs only when requested
// - without on-request, runs whenever enabled
// - standby without run-in-standby stops oscillator
// - standby with run-in-standby keeps normal behaviour
// - bit 3 gates the 1 kHz output
// - bit 2 gates the 32 kHz output
// - low-power control lock blocks writes
// - low-power trim loaded from flash at start
// - fast divider divides by 1, 2, 4, 8
// - fast range and trim loaded from flash
package lfo_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_XOSC = 8'h14;
   localparam logic [7:0] OFS_SLOW = 8'h18;
   localparam logic [7:0] OFS_ULP = 8'h1C;
   localparam logic [7:0] OFS_FAST = 8'h20;
   // writable bits and values after reset
   localparam logic [31:0] XOSC_WMASK = 32'h00000086;
   localparam logic [31:0] XOSC_RESET = 32'h00000080;
   localparam logic [31:0] SLOW_WMASK = 32'h007F17CE;
   localparam logic [31:0] SLOW_RESET = 32'h003F0080;
   localparam logic [31:0] ULP_WMASK = 32'h0000009F;
   localparam logic [31:0] ULP_RESET = 32'h00000000;
   localparam logic [31:0] FAST_WMASK = 32'hCFFF03C2;
   localparam logic [31:0] FAST_RESET = 32'h87070382;
   // shared field positions
   localparam int ENABLE_BIT = 1;
   localparam int XTAL_BIT = 2;
   localparam int K32_BIT = 2;
   localparam int K1_BIT = 3;
   localparam int STBY_BIT = 6;
   localparam int ONDEM_BIT = 7;
   localparam int SLOW_LOCK_BIT = 12;
   localparam int ULP_LOCK_BIT = 7;
   localparam int STARTUP_LSB = 8;
   localparam int SLOW_CAL_LSB = 16;
   localparam int OUTPUT_DIVIDER_LSB = 8;
   localparam int FAST_CAL_LSB = 16;
   localparam int FREQUENCY_RANGE_SELECT_LSB = 30;
   // status bits
   localparam int ST_SLOW_RDY = 0;
   localparam int ST_SLOW_RUN = 1;
   localparam int ST_FAST_RUN = 2;
   localparam int ST_XOSC_EN = 3;
   // timing: system clock and low-power source rate
   localparam int CLK_HZ = 25000000;
   localparam int ULP_HZ = 32768;
   localparam int ULP_DIV_CYC = CLK_HZ / ULP_HZ;
   localparam int K1_DIV = 32;
   localparam int SYNC_CYC = 2;

   // run decision shared by the slow and fast oscillators
   function automatic logic lfo_osc_gate(input logic en, input logic ondem,
                                         input logic stby_ok, input logic standby,
                                         input logic req);
      lfo_osc_gate = en & (~standby | stby_ok) & (~ondem | req);
   endfunction

   // start-up cycles per code, plus synchronisation
   function automatic logic [7:0] lfo_startup_limit(input logic [2:0] sel);
      logic [7:0] n;
      case (sel)
         3'h0: n = 8'h03;
         3'h1: n = 8'h04;
         3'h2: n = 8'h06;
         3'h3: n = 8'h0A;
         3'h4: n = 8'h12;
         3'h5: n = 8'h22;
         3'h6: n = 8'h42;
         default: n = 8'h82;
      endcase
      lfo_startup_limit = n + 8'(SYNC_CYC);
   endfunction
endpackage

// ==== rtl/lfo_ctrl.sv ====
// apb register block and run control for the slow, low-power and fast oscillators
`timescale 1ns/100ps
`default_nettype none
module lfo_ctrl #(
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // power state and clock requests
   input wire logic standby_sleep,
   input wire logic slow_clk_request,
   input wire logic fast_clk_request,
   // flash calibration values
   input wire logic [4:0] ulp_trim_load,
   input wire logic [1:0] fast_range_load,
   input wire logic [11:0] fast_trim_load,
   // external slow oscillator pads
   output logic crystal_pad_select,
   output logic output_pad_gpio_free,
   output logic ext_slow_osc_enable,
   // internal slow oscillator
   output logic slow_osc_run,
   output logic [6:0] slow_trim,
   output logic internal_slow_ready_flag,
   output logic khz32_tick,
   output logic khz1_tick,
   // low-power oscillator
   output logic [4:0] ulp_trim,
   // internal fast oscillator
   output logic fast_osc_run,
   output logic [1:0] frequency_range_select,
   output logic [11:0] fast_trim,
   output logic fast_div_tick
);
   // elaboration check: the decode reads the low eight address bits
   if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_w_check
      $error("ADDR_W must lie between 8 and 32");
   end

   logic [31:0] xosc_r;
   logic [31:0] slow_r;
   logic [31:0] ulp_r;
   logic [31:0] fast_r;
   logic [31:0] rdata_r;
   logic load_pend_r;
   logic slow_run_r;
   logic fast_run_r;
   logic [9:0] ulp_cnt_r;
   logic ulp_tick_r;
   logic [4:0] k1_cnt_r;
   logic k32_r;
   logic k1_r;
   logic slow_rdy;

   // address decode; upper address bits must be zero
   // aliases would let a stray address hit a live register
   wire logic [7:0] ofs = paddr[7:0];
   wire logic hi_zero = (paddr >> 8) == '0;
   wire logic hit_st = hi_zero && ofs == lfo_pkg::OFS_STATUS;
   wire logic hit_xosc = hi_zero && ofs == lfo_pkg::OFS_XOSC;
   wire logic hit_slow = hi_zero && ofs == lfo_pkg::OFS_SLOW;
   wire logic hit_ulp = hi_zero && ofs == lfo_pkg::OFS_ULP;
   wire logic hit_fast = hi_zero && ofs == lfo_pkg::OFS_FAST;
   wire logic mapped = hit_st | hit_xosc | hit_slow | hit_ulp | hit_fast;
   wire logic setup = psel & ~penable;
   wire logic access = psel & penable;
   wire logic wr = access & pwrite & mapped;

   // a lock set by a write still lets that same write land
   // locked slow control ignores writes
   wire logic slow_locked = slow_r[lfo_pkg::SLOW_LOCK_BIT];
   wire logic ulp_locked = ulp_r[lfo_pkg::ULP_LOCK_BIT];
   wire logic wr_xosc = wr & hit_xosc;
   wire logic wr_slow = wr & hit_slow & ~slow_locked;
   wire logic wr_ulp = wr & hit_ulp & ~ulp_locked;
   wire logic wr_fast = wr & hit_fast;

   // status word shows live oscillator state
   // status bits are read-only; writes there are dropped quietly
   wire logic [31:0] status_word = {28'h0000000,
      xosc_r[lfo_pkg::ENABLE_BIT], fast_run_r, slow_run_r, slow_rdy};

   wire logic [31:0] rd_mux =
      ({32{hit_st}} & status_word) |
      ({32{hit_xosc}} & xosc_r) |
      ({32{hit_slow}} & slow_r) |
      ({32{hit_ulp}} & ulp_r) |
      ({32{hit_fast}} & fast_r);

   // every register is a flop, so no wait state is ever needed
   // zero wait slave; unmapped access flags an error
   assign pready = 1'b1;
   assign pslverr = access & ~mapped;
   assign prdata = rdata_r;

   // read data caught in the setup cycle
   // trade: data is one edge old, but prdata never glitches
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_r <= 32'h00000000;
      end else if (setup) begin
         rdata_r <= pwrite ? 32'h00000000 : rd_mux;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xosc_r <= lfo_pkg::XOSC_RESET;
      end else if (wr_xosc) begin
         xosc_r <= pwdata & lfo_pkg::XOSC_WMASK;
      end
   end

   // trim stays at its reset value until software writes it
   // trim comes only from software writes
   // lock bit clears only on reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_r <= lfo_pkg::SLOW_RESET;
      end else if (wr_slow) begin
         slow_r <= pwdata & lfo_pkg::SLOW_WMASK;
      end
   end

   // one pending load after reset release
   // flash words are levels; one capture suffices and beats a write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_pend_r <= 1'b1;
      end else begin
         load_pend_r <= 1'b0;
      end
   end

   // trim taken from flash after release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ulp_r <= lfo_pkg::ULP_RESET;
      end else if (load_pend_r) begin
         ulp_r <= {27'h0000000, ulp_trim_load};
      end else if (wr_ulp) begin
         ulp_r <= pwdata & lfo_pkg::ULP_WMASK;
      end
   end

   // range and trim taken from flash
   // divider and mode bits keep their reset value across the load
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fast_r <= lfo_pkg::FAST_RESET;
      end else if (load_pend_r) begin
         fast_r <= {fast_range_load, 2'b00, fast_trim_load, fast_r[15:0]};
      end else if (wr_fast) begin
         fast_r <= pwdata & lfo_pkg::FAST_WMASK;
      end
   end

   // field extraction
   wire logic slow_en = slow_r[lfo_pkg::ENABLE_BIT];
   wire logic slow_ondem = slow_r[lfo_pkg::ONDEM_BIT];
   wire logic slow_stby = slow_r[lfo_pkg::STBY_BIT];
   wire logic fast_en = fast_r[lfo_pkg::ENABLE_BIT];
   wire logic fast_ondem = fast_r[lfo_pkg::ONDEM_BIT];
   wire logic fast_stby = fast_r[lfo_pkg::STBY_BIT];
   wire logic [2:0] startup_sel = slow_r[lfo_pkg::STARTUP_LSB +: 3];

   wire logic slow_run_nxt = lfo_pkg::lfo_osc_gate(slow_en, slow_ondem,
      slow_stby, standby_sleep, slow_clk_request);
   wire logic fast_run_nxt = lfo_pkg::lfo_osc_gate(fast_en, fast_ondem,
      fast_stby, standby_sleep, fast_clk_request);

   // registered run enables avoid glitches on the oscillator control
   // a request change shows on the run output one edge later
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_run_r <= 1'b0;
         fast_run_r <= 1'b0;
      end else begin
         slow_run_r <= slow_run_nxt;
         fast_run_r <= fast_run_nxt;
      end
   end

   // low-power source stands in as a 32 kHz enable
   // a divider keeps one clock domain instead of a second source clock
   // limitation: whole cycles per tick, a little fast of the true rate
   wire logic ulp_wrap = (ulp_cnt_r == 10'(lfo_pkg::ULP_DIV_CYC - 1));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ulp_cnt_r <= 10'h000;
         ulp_tick_r <= 1'b0;
      end else begin
         ulp_cnt_r <= ulp_wrap ? 10'h000 : ulp_cnt_r + 10'h001;
         ulp_tick_r <= ulp_wrap;
      end
   end

   lfo_startup lfo_startup_inst (
      .pclk(pclk),
      .presetn(presetn),
      .ulp_tick(ulp_tick_r),
      .osc_run(slow_run_r),
      .startup_sel(startup_sel),
      .ready(slow_rdy)
   );

   // 1 kHz enable is every 32nd slow tick
   // limitation: the 1 kHz phase restarts whenever the oscillator does
   wire logic k1_wrap = (k1_cnt_r == 5'(lfo_pkg::K1_DIV - 1));
   wire logic slow_live = slow_run_r & slow_rdy;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         k1_cnt_r <= 5'h00;
      end else if (!slow_live) begin
         k1_cnt_r <= 5'h00;
      end else if (ulp_tick_r) begin
         k1_cnt_r <= k1_cnt_r + 5'h01;
      end
   end

   // output gates, no ticks before ready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         k32_r <= 1'b0;
         k1_r <= 1'b0;
      end else begin
         k32_r <= slow_live & ulp_tick_r & slow_r[lfo_pkg::K32_BIT];
         k1_r <= slow_live & ulp_tick_r & k1_wrap & slow_r[lfo_pkg::K1_BIT];
      end
   end

   lfo_divider lfo_divider_inst (
      .pclk(pclk),
      .presetn(presetn),
      .osc_run(fast_run_r),
      .output_divider(fast_r[lfo_pkg::OUTPUT_DIVIDER_LSB +: 2]),
      .div_tick(fast_div_tick)
   );

   // output mapping from registers
   // gpio-free is the crystal select inverted, so pads never disagree
   assign crystal_pad_select = xosc_r[lfo_pkg::XTAL_BIT];
   assign output_pad_gpio_free = ~xosc_r[lfo_pkg::XTAL_BIT];
   assign ext_slow_osc_enable = xosc_r[lfo_pkg::ENABLE_BIT];
   assign slow_osc_run = slow_run_r;
   assign slow_trim = slow_r[lfo_pkg::SLOW_CAL_LSB +: 7];
   assign internal_slow_ready_flag = slow_rdy;
   assign khz32_tick = k32_r;
   assign khz1_tick = k1_r;
   assign ulp_trim = ulp_r[4:0];
   assign frequency_range_select = fast_r[lfo_pkg::FREQUENCY_RANGE_SELECT_LSB +: 2];
   assign fast_trim = fast_r[lfo_pkg::FAST_CAL_LSB +: 12];
   assign fast_osc_run = fast_run_r;

   // checks next to the logic they guard
   slow_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
      (slow_locked && access && pwrite && hit_slow) |=> $stable(slow_r))
      else $error("locked slow control changed");
   ulp_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
      (ulp_locked && !load_pend_r && access && pwrite && hit_ulp) |=> $stable(ulp_r))
      else $error("locked low-power control changed");
   lock_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
      slow_locked |=> slow_locked)
      else $error("slow lock cleared without reset");
   reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      (access && !pwrite && hit_slow) |-> (prdata & ~lfo_pkg::SLOW_WMASK) == '0)
      else $error("reserved slow bits read nonzero");
   stby_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      (standby_sleep && !slow_stby) |=> !slow_run_r)
      else $error("slow oscillator ran in standby");
   run_on_request_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
      (fast_ondem && !fast_clk_request) |=> !fast_run_r)
      else $error("fast oscillator ran without request");
   always_on_a: assert property (@(posedge pclk) disable iff (!presetn)
      (slow_en && !slow_ondem && (!standby_sleep || slow_stby)) |=> slow_run_r)
      else $error("enabled slow oscillator not running");
   disable_run_a: assert property (@(posedge pclk) disable iff (!presetn)
      !slow_en |=> !slow_run_r)
      else $error("disabled slow oscillator running");
   khz1_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      !slow_r[lfo_pkg::K1_BIT] |=> !k1_r)
      else $error("1 kHz tick while gated");
   khz32_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      !slow_r[lfo_pkg::K32_BIT] |=> !k32_r)
      else $error("32 kHz tick while gated");
   flash_load_a: assert property (@(posedge pclk) disable iff (!presetn)
      load_pend_r |=> ulp_r[4:0] == $past(ulp_trim_load))
      else $error("low-power trim not loaded from flash");
   fast_load_a: assert property (@(posedge pclk) disable iff (!presetn)
      load_pend_r |=> fast_trim == $past(fast_trim_load))
      else $error("fast trim not loaded from flash");

   // register writes and reads
   slow_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_slow |=> slow_r == ($past(pwdata) & lfo_pkg::SLOW_WMASK))
      else $error("slow control write lost");
   fast_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_fast && !load_pend_r) |=> fast_r == ($past(pwdata) & lfo_pkg::FAST_WMASK))
      else $error("fast control write lost");
   ulp_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_ulp && !load_pend_r) |=> ulp_r == ($past(pwdata) & lfo_pkg::ULP_WMASK))
      else $error("low-power control write lost");
   xosc_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_xosc |=> xosc_r == ($past(pwdata) & lfo_pkg::XOSC_WMASK))
      else $error("external control write lost");
   status_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && hit_st) |=> prdata == $past(status_word))
      else $error("status read returned stale data");
   // pads, run decisions and ticks
   pad_select_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_xosc |=> crystal_pad_select == $past(pwdata[lfo_pkg::XTAL_BIT]))
      else $error("pad select did not follow write");
   slow_request_a: assert property (@(posedge pclk) disable iff (!presetn)
      (slow_ondem && !slow_clk_request) |=> !slow_run_r)
      else $error("slow oscillator ran without request");
   standby_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
      (standby_sleep && slow_stby && slow_en && (!slow_ondem || slow_clk_request))
      |=> slow_run_r)
      else $error("slow oscillator stopped in standby");
   fast_stby_a: assert property (@(posedge pclk) disable iff (!presetn)
      (standby_sleep && !fast_stby) |=> !fast_run_r)
      else $error("fast oscillator ran in standby");
   fast_on_a: assert property (@(posedge pclk) disable iff (!presetn)
      (fast_en && !fast_ondem && (!standby_sleep || fast_stby)) |=> fast_run_r)
      else $error("enabled fast oscillator not running");
   tick_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
      !slow_live |=> (!k32_r && !k1_r))
      else $error("output tick before ready");
   khz1_count_a: assert property (@(posedge pclk) disable iff (!presetn)
      k1_r |-> k1_cnt_r == 5'h00)
      else $error("1 kHz tick off the 32 tick boundary");
   khz32_src_a: assert property (@(posedge pclk) disable iff (!presetn)
      k32_r |-> ($past(ulp_tick_r) && $past(slow_live)))
      else $error("32 kHz tick without a source tick");
endmodule
`default_nettype wire

// ==== rtl/lfo_divider.sv ====
// output divider of the internal fast oscillator
`timescale 1ns/100ps
`default_nettype none
module lfo_divider (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic osc_run,
   input wire logic [1:0] output_divider,
   // divided clock enable
   output logic div_tick
);
   logic [2:0] cnt_r;
   logic tick_r;
   wire logic [2:0] mask = 3'((4'h1 << output_divider) - 4'h1);
   wire logic wrap = ((cnt_r & mask) == mask);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 3'h0;
         tick_r <= 1'b0;
      end else begin
         cnt_r <= osc_run ? cnt_r + 3'h1 : 3'h0;
         tick_r <= osc_run & wrap;
      end
   end

   assign div_tick = tick_r;

   // a tick launched under the previous divider setting is not judged
   div_eight_a: assert property (@(posedge pclk) disable iff (!presetn)
      (tick_r && output_divider == 2'h3 && $stable(output_divider)) |=> (!tick_r || output_divider != 2'h3) [*7])
      else $error("divide by eight ticked early");
endmodule
`default_nettype wire

// ==== rtl/lfo_startup.sv ====
// start-up counter and ready flag of the internal slow oscillator
`timescale 1ns/100ps
`default_nettype none
module lfo_startup (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // low-power source tick and control
   input wire logic ulp_tick,
   input wire logic osc_run,
   input wire logic [2:0] startup_sel,
   // status
   output logic ready
);
   logic [7:0] cnt_r;
   logic ready_r;
   wire logic [7:0] limit = lfo_pkg::lfo_startup_limit(startup_sel);
   wire logic reached = (cnt_r >= limit);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 8'h00;
      end else if (!osc_run) begin
         cnt_r <= 8'h00;
      end else if (ulp_tick && !reached) begin
         cnt_r <= cnt_r + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_r <= 1'b0;
      end else begin
         ready_r <= osc_run & reached;
      end
   end

   assign ready = ready_r;

   ready_count_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(ready_r) |-> $past(cnt_r) >= $past(limit))
      else $error("ready rose before start-up count");
   ready_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
      !osc_run |=> !ready_r)
      else $error("ready held while oscillator stopped");
endmodule
`default_nettype wire
